// [common/svw_pkg.sv]
// Shared constants and types for the supervisor watchdog and power-on timer
package svw_pkg;

  // Time base: a 1 us tick derived from the 8 ns bus clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int TMR_W = 24;

  // Power-on reset delays
  localparam int POR_T0_MS = 50;
  localparam int POR_T1_MS = 200;
  localparam int POR_T2_MS = 400;
  localparam int POR_T3_MS = 800;
  localparam logic [TMR_W-1:0] POR_TICKS_0 = TMR_W'(POR_T0_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] POR_TICKS_1 = TMR_W'(POR_T1_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] POR_TICKS_2 = TMR_W'(POR_T2_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] POR_TICKS_3 = TMR_W'(POR_T3_MS * TICKS_PER_MS);

  // Watchdog periods
  localparam real WDT_T0_S = 1.4;
  localparam int WDT_T1_MS = 200;
  localparam int WDT_T2_MS = 25;
  localparam logic [TMR_W-1:0] WDT_TICKS_0 = TMR_W'(int'(WDT_T0_S * 1000.0 * TICKS_PER_MS));
  localparam logic [TMR_W-1:0] WDT_TICKS_1 = TMR_W'(WDT_T1_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] WDT_TICKS_2 = TMR_W'(WDT_T2_MS * TICKS_PER_MS);

  // Watchdog reset hold times, nominal value of each window
  localparam int WRST_LONG_MS = 200;
  localparam int WRST_SHORT_MS = 25;
  localparam logic [TMR_W-1:0] WRST_LONG_TICKS = TMR_W'(WRST_LONG_MS * TICKS_PER_MS);
  localparam logic [TMR_W-1:0] WRST_SHORT_TICKS = TMR_W'(WRST_SHORT_MS * TICKS_PER_MS);

  // Self-timed nonvolatile write: typical and worst case
  localparam int NVW_TYP_MS = 5;
  localparam int NVW_MAX_MS = 10;
  localparam logic [TMR_W-1:0] NVW_TICKS = TMR_W'(NVW_TYP_MS * TICKS_PER_MS);

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RESTART = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;

  // Field positions
  localparam int CTRL_POR_LSB = 0;
  localparam int CTRL_WDT_LSB = 2;
  localparam int STATE_POR_ACTIVE = 0;
  localparam int STATE_WDT_HOLD = 1;
  localparam int STATE_NVW_BUSY = 2;
  localparam int STATE_WDT_EN = 3;
  localparam int IRQ_WDT = 0;
  localparam int IRQ_NVW = 1;
  localparam int IRQ_POR = 2;
  localparam int IRQ_W = 3;

  // Reset values and select codes
  localparam logic [1:0] POR_SEL_RST = 2'h1;
  localparam logic [1:0] WDT_SEL_RST = 2'h3;
  localparam logic [1:0] WDT_SEL_OFF = 2'h3;
  localparam logic [1:0] WDT_SEL_SHORT = 2'h2;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 3'h0;

  typedef enum logic [1:0] {WDT_OFF, WDT_RUN, WDT_HOLD} svw_wdt_st_t;

endpackage : svw_pkg

// [core/svw_timer.sv]
// One-shot down counter stepped by the shared microsecond tick
`timescale 1ns/1ps
module svw_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  // Status
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } svw_tmr_st_t;

  svw_tmr_st_t s;
  svw_tmr_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (stop) begin
      next_s.busy = 1'b0;
    end else if (start) begin
      next_s.cnt = load_val;
      next_s.busy = 1'b1;
    end else if (s.busy && tick) begin
      if (s.cnt <= W'(1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;

endmodule : svw_timer

// [core/svw_core.sv]
// Supervisor timing core: power-on reset delay, watchdog and self-timed write, AHB-Lite registers
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module svw_core #(
  parameter int TICK_CYC = svw_pkg::TICK_CYC,
  parameter logic [svw_pkg::TMR_W-1:0] POR_TICKS_0 = svw_pkg::POR_TICKS_0,
  parameter logic [svw_pkg::TMR_W-1:0] POR_TICKS_1 = svw_pkg::POR_TICKS_1,
  parameter logic [svw_pkg::TMR_W-1:0] POR_TICKS_2 = svw_pkg::POR_TICKS_2,
  parameter logic [svw_pkg::TMR_W-1:0] POR_TICKS_3 = svw_pkg::POR_TICKS_3,
  parameter logic [svw_pkg::TMR_W-1:0] WDT_TICKS_0 = svw_pkg::WDT_TICKS_0,
  parameter logic [svw_pkg::TMR_W-1:0] WDT_TICKS_1 = svw_pkg::WDT_TICKS_1,
  parameter logic [svw_pkg::TMR_W-1:0] WDT_TICKS_2 = svw_pkg::WDT_TICKS_2,
  parameter logic [svw_pkg::TMR_W-1:0] WRST_LONG_TICKS = svw_pkg::WRST_LONG_TICKS,
  parameter logic [svw_pkg::TMR_W-1:0] WRST_SHORT_TICKS = svw_pkg::WRST_SHORT_TICKS,
  parameter logic [svw_pkg::TMR_W-1:0] NVW_TICKS = svw_pkg::NVW_TICKS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Restart pin from the host
  input wire logic wdt_kick,
  // Supervisor outputs
  output logic reset_out_n,
  output logic watchdog_out_n,
  output logic irq
);

  localparam int TW = svw_pkg::TMR_W;

  typedef struct packed {
    logic [1:0] por_sel;
    logic [1:0] wdt_sel;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [svw_pkg::IRQ_W-1:0] sts;
    logic [svw_pkg::IRQ_W-1:0] msk;
    logic [2:0] kick_sync;
    logic kick_lvl;
    logic [7:0] pre;
    logic tick;
    logic por_started;
    logic por_n;
    logic wdo_n;
    logic irq;
    logic hreadyout;
    svw_pkg::svw_wdt_st_t wdt_st;
  } svw_core_st_t;

  localparam svw_core_st_t ST_RST = '{
    por_sel: svw_pkg::POR_SEL_RST, wdt_sel: svw_pkg::WDT_SEL_RST,
    wr_pend: 1'b0, wr_addr: 8'h00, rdata: 32'h0000_0000,
    sts: 3'h0, msk: svw_pkg::IRQ_MSK_RST, kick_sync: 3'h0, kick_lvl: 1'b0,
    pre: 8'h00, tick: 1'b0, por_started: 1'b0, por_n: 1'b0, wdo_n: 1'b1,
    irq: 1'b0, hreadyout: 1'b1, wdt_st: svw_pkg::WDT_OFF};

  svw_core_st_t s;
  svw_core_st_t next_s;

  logic por_start, por_done;
  logic wdt_start, wdt_stop, wdt_busy, wdt_done;
  logic rst_start, rst_busy, rst_done;
  logic nvw_start, nvw_busy, nvw_done;
  logic restart;
  logic [TW-1:0] wdt_load;
  logic [svw_pkg::IRQ_W-1:0] sts_set, sts_clr;

  function automatic logic [TW-1:0] por_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: por_ticks = POR_TICKS_0;
      2'h1: por_ticks = POR_TICKS_1;
      2'h2: por_ticks = POR_TICKS_2;
      default: por_ticks = POR_TICKS_3;
    endcase
  endfunction : por_ticks

  function automatic logic [TW-1:0] wdt_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: wdt_ticks = WDT_TICKS_0;
      2'h1: wdt_ticks = WDT_TICKS_1;
      default: wdt_ticks = WDT_TICKS_2;
    endcase
  endfunction : wdt_ticks

  function automatic logic [TW-1:0] rst_ticks(input logic [1:0] sel);
    rst_ticks = (sel == svw_pkg::WDT_SEL_SHORT) ? WRST_SHORT_TICKS : WRST_LONG_TICKS;
  endfunction : rst_ticks

  always_comb begin
    next_s = s;
    por_start = 1'b0;
    wdt_start = 1'b0;
    wdt_stop = 1'b0;
    rst_start = 1'b0;
    nvw_start = 1'b0;
    restart = 1'b0;
    sts_set = '0;
    sts_clr = '0;
    // Microsecond time base
    next_s.tick = 1'b0;
    if (s.pre == 8'(TICK_CYC - 1)) begin
      next_s.pre = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.pre = s.pre + 8'h01;
    end
    // Restart pin: three stages, a change counts once the last two agree
    next_s.kick_sync = {s.kick_sync[1:0], wdt_kick};
    if (s.kick_sync[2] == s.kick_sync[1]) begin
      next_s.kick_lvl = s.kick_sync[2];
      restart = s.kick_sync[2] & ~s.kick_lvl;
    end
    // Bus address phase: zero wait states, reads answered from a flop
    next_s.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = haddr[7:0];
      end else begin
        case (haddr[7:0])
          svw_pkg::ADDR_CTRL: next_s.rdata = {28'h0, s.wdt_sel, s.por_sel};
          svw_pkg::ADDR_STATE: next_s.rdata = {28'h0, s.wdt_sel != svw_pkg::WDT_SEL_OFF,
                                               nvw_busy, s.wdt_st == svw_pkg::WDT_HOLD, ~s.por_n};
          svw_pkg::ADDR_IRQ_STS: next_s.rdata = {29'h0, s.sts};
          svw_pkg::ADDR_IRQ_MSK: next_s.rdata = {29'h0, s.msk};
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Bus data phase
    if (s.wr_pend) begin
      case (s.wr_addr)
        svw_pkg::ADDR_CTRL: begin
          // Settings take a self-timed write but reload their reset values on reset: a write is refused while the last one is still busy
          if (!nvw_busy) begin
            next_s.por_sel = hwdata[svw_pkg::CTRL_POR_LSB +: 2];
            next_s.wdt_sel = hwdata[svw_pkg::CTRL_WDT_LSB +: 2];
            nvw_start = 1'b1;
          end
        end
        svw_pkg::ADDR_RESTART: restart = 1'b1;
        svw_pkg::ADDR_IRQ_STS: sts_clr = hwdata[svw_pkg::IRQ_W-1:0];
        svw_pkg::ADDR_IRQ_MSK: next_s.msk = hwdata[svw_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // Power-on reset, launched once after reset release
    if (!s.por_started) begin
      next_s.por_started = 1'b1;
      por_start = 1'b1;
    end
    if (por_done) begin
      next_s.por_n = 1'b1;
      sts_set[svw_pkg::IRQ_POR] = 1'b1;
    end
    // Watchdog
    case (s.wdt_st)
      svw_pkg::WDT_OFF: begin
        if (s.por_n && s.wdt_sel != svw_pkg::WDT_SEL_OFF) begin
          wdt_start = 1'b1;
          next_s.wdt_st = svw_pkg::WDT_RUN;
        end
      end
      svw_pkg::WDT_RUN: begin
        if (s.wdt_sel == svw_pkg::WDT_SEL_OFF) begin
          wdt_stop = 1'b1;
          next_s.wdt_st = svw_pkg::WDT_OFF;
        end else if (restart || nvw_start) begin
          wdt_start = 1'b1;
        end else if (wdt_done) begin
          next_s.wdo_n = 1'b0;
          rst_start = 1'b1;
          next_s.wdt_st = svw_pkg::WDT_HOLD;
          sts_set[svw_pkg::IRQ_WDT] = 1'b1;
        end
      end
      svw_pkg::WDT_HOLD: begin
        if (rst_done) begin
          next_s.wdo_n = 1'b1;
          next_s.wdt_st = svw_pkg::WDT_OFF;
        end
      end
      default: next_s.wdt_st = svw_pkg::WDT_OFF;
    endcase
    if (nvw_done) begin
      sts_set[svw_pkg::IRQ_NVW] = 1'b1;
    end
    // Set wins over a clear in the same cycle
    next_s.sts = (s.sts & ~sts_clr) | sts_set;
    next_s.irq = |(next_s.sts & next_s.msk);
  end

  assign wdt_load = wdt_ticks(next_s.wdt_sel);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  svw_timer #(.W(TW)) u_por (
    .hclk(hclk), .hresetn(hresetn), .start(por_start), .stop(1'b0),
    .load_val(por_ticks(s.por_sel)), .tick(s.tick), .busy(), .done(por_done));

  svw_timer #(.W(TW)) u_wdt (
    .hclk(hclk), .hresetn(hresetn), .start(wdt_start), .stop(wdt_stop),
    .load_val(wdt_load), .tick(s.tick), .busy(wdt_busy), .done(wdt_done));

  svw_timer #(.W(TW)) u_rst (
    .hclk(hclk), .hresetn(hresetn), .start(rst_start), .stop(1'b0),
    .load_val(rst_ticks(s.wdt_sel)), .tick(s.tick), .busy(rst_busy), .done(rst_done));

  svw_timer #(.W(TW)) u_nvw (
    .hclk(hclk), .hresetn(hresetn), .start(nvw_start), .stop(1'b0),
    .load_val(NVW_TICKS), .tick(s.tick), .busy(nvw_busy), .done(nvw_done));

  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign reset_out_n = s.por_n;
  assign watchdog_out_n = s.wdo_n;
  assign irq = s.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_expire;
    s.wdt_st == svw_pkg::WDT_RUN && wdt_done && !restart && !nvw_start &&
      s.wdt_sel != svw_pkg::WDT_SEL_OFF;
  endsequence

  sequence s_hold_end;
    s.wdt_st == svw_pkg::WDT_HOLD && rst_done;
  endsequence

  AST_POR_RELEASE: assert property ($rose(reset_out_n) |-> $past(por_done))
    else $error("power-on reset released without its delay ending");
  AST_POR_HELD: assert property (!s.por_n && !por_done |=> !reset_out_n)
    else $error("power-on reset released early");
  AST_WDT_OFF: assert property (s.wdt_sel == svw_pkg::WDT_SEL_OFF && !rst_busy |=> !wdt_busy)
    else $error("watchdog counting while disabled");
  AST_WDT_EXPIRE: assert property (s_expire |=> !watchdog_out_n && rst_busy)
    else $error("watchdog expiry did not drive the output low");
  AST_WDO_CAUSE: assert property ($fell(watchdog_out_n) |-> $past(wdt_done))
    else $error("watchdog output fell without expiry");
  AST_RST_HOLD: assert property (s.wdt_st == svw_pkg::WDT_HOLD && !rst_done |=> !watchdog_out_n)
    else $error("watchdog reset released before its time-out");
  AST_RST_END: assert property (s_hold_end |=> watchdog_out_n ##1 watchdog_out_n)
    else $error("watchdog reset not released after its time-out");
  AST_NVW_START: assert property (nvw_start |=> nvw_busy)
    else $error("nonvolatile write did not start");
  AST_NVW_REFUSE: assert property (s.wr_pend && s.wr_addr == svw_pkg::ADDR_CTRL && nvw_busy
    |=> $stable(s.wdt_sel) && $stable(s.por_sel))
    else $error("settings changed during a nonvolatile write");
  // A masked-in event must raise the interrupt even against a clear in the same cycle
  AST_IRQ_LEVEL: assert property (|(sts_set & s.msk) &&
    !(s.wr_pend && s.wr_addr == svw_pkg::ADDR_IRQ_MSK) |=> irq)
    else $error("masked-in event did not raise the interrupt");

endmodule : svw_core

// [dv/svw_host_model.sv]
// Host model that sends restart pulses on the watchdog restart pin
`timescale 1ns/1ps
module svw_host_model #(
  parameter int PULSE_CYC = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench request and restart pin
  input wire logic kick_req,
  output logic wdt_kick
);
  logic [7:0] cnt;
  // Pin is high for PULSE_CYC clocks, then low for at least PULSE_CYC + 1 clocks before the next pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (kick_req) begin
      cnt <= 8'(2 * PULSE_CYC);
    end
  end
  assign wdt_kick = (cnt > 8'(PULSE_CYC));
endmodule : svw_host_model

// [dv/svw_core_tb.sv]
// Self-checking bench for the supervisor timing core
`timescale 1ns/1ps
module svw_core_tb;
  localparam int TC = 2;
  localparam int PT1 = 14;
  localparam int NVT = 12;
  localparam int WP [3] = '{34, 20, 8};
  localparam int WH [3] = '{16, 16, 6};
  logic hclk, hresetn, hsel, hwrite, kick_req, wdt_kick, guard;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, reset_out_n, watchdog_out_n, irq;
  int error_cnt, samples_checked, n;
  time t0;

  svw_core #(.TICK_CYC(TC), .POR_TICKS_1(24'(PT1)), .WDT_TICKS_0(24'(WP[0])),
    .WDT_TICKS_1(24'(WP[1])), .WDT_TICKS_2(24'(WP[2])), .WRST_LONG_TICKS(24'(WH[0])),
    .WRST_SHORT_TICKS(24'(WH[2])), .NVW_TICKS(24'(NVT))) svw_core_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wdt_kick(wdt_kick),
    .reset_out_n(reset_out_n), .watchdog_out_n(watchdog_out_n), .irq(irq));

  svw_host_model svw_host_model_i (
    .hclk(hclk), .hresetn(hresetn), .kick_req(kick_req), .wdt_kick(wdt_kick));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task conclude;
    $display("mismatches=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task rng(input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h lo=%h hi=%h", $time, v, lo, hi);
    end
  endtask : rng

  task rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 100) begin
        error_cnt++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask : rdy

  // One single-word transfer: address phase, then data phase
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rdc

  // Cycles until the chosen output reaches lvl
  task meas(input logic wd, input logic lvl, output int c);
    c = 0;
    while ((wd ? watchdog_out_n : reset_out_n) !== lvl) begin
      @(negedge hclk);
      c++;
      if (c > 3000) begin
        error_cnt++;
        conclude();
      end
    end
  endtask : meas

  // Acknowledge polling on the write busy flag
  task nvw;
    int k;
    k = 0;
    ahb(1'b0, svw_pkg::ADDR_STATE, 32'h00000000);
    while (rd[svw_pkg::STATE_NVW_BUSY] !== 1'b0) begin
      k++;
      if (k > 200) begin
        error_cnt++;
        conclude();
      end
      ahb(1'b0, svw_pkg::ADDR_STATE, 32'h00000000);
    end
  endtask : nvw

  // Watchdog output must stay high while guarded
  always @(negedge hclk) begin
    if (guard && watchdog_out_n !== 1'b1) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, watchdog_out_n, 1'b1);
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    kick_req = 1'b0;
    guard = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk({31'h0, reset_out_n}, 32'h00000000);
    meas(1'b0, 1'b1, n);
    rng(n, (PT1 - 1) * TC, PT1 * TC + 6);
    rdc(svw_pkg::ADDR_CTRL, 32'h0000000D);
    rdc(svw_pkg::ADDR_STATE, 32'h00000000);
    rdc(svw_pkg::ADDR_IRQ_STS, 32'h00000004);
    rdc(svw_pkg::ADDR_IRQ_MSK, 32'h00000000);
    rdc(8'h20, 32'h00000000);
    wr(svw_pkg::ADDR_IRQ_MSK, 32'h00000004);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h00000001);
    wr(svw_pkg::ADDR_IRQ_STS, 32'h00000004);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h00000000);
    // Self-timed write, a refused second write, then polling
    wr(svw_pkg::ADDR_CTRL, 32'h0000000C);
    t0 = $time;
    rdc(svw_pkg::ADDR_STATE, 32'h00000004);
    wr(svw_pkg::ADDR_CTRL, 32'h00000000);
    nvw();
    rng(int'(($time - t0) / 8), (NVT - 1) * TC - 2, NVT * TC + 8);
    rdc(svw_pkg::ADDR_CTRL, 32'h0000000C);
    rdc(svw_pkg::ADDR_IRQ_STS, 32'h00000002);
    wr(svw_pkg::ADDR_IRQ_STS, 32'h00000007);
    guard <= 1'b1;
    repeat (100) @(posedge hclk);
    guard <= 1'b0;
    // Each enabled period and its reset hold time
    for (int i = 0; i < 3; i++) begin
      nvw();
      wr(svw_pkg::ADDR_CTRL, 32'(i << 2));
      meas(1'b1, 1'b0, n);
      rng(n, (WP[i] - 1) * TC, WP[i] * TC + 6);
      meas(1'b1, 1'b1, n);
      rng(n, (WH[i] - 1) * TC, WH[i] * TC + 4);
      ahb(1'b0, svw_pkg::ADDR_IRQ_STS, 32'h00000000);
      chk(rd & 32'h00000001, 32'h00000001);
      wr(svw_pkg::ADDR_IRQ_STS, 32'h00000007);
    end
    // Restarts from pin and register keep the short watchdog quiet
    nvw();
    wr(svw_pkg::ADDR_CTRL, 32'h00000008);
    guard <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      if (j % 2 == 1) begin
        wr(svw_pkg::ADDR_RESTART, 32'h00000000);
      end else begin
        kick_req <= 1'b1;
        @(posedge hclk);
        kick_req <= 1'b0;
      end
      repeat (3) @(posedge hclk);
    end
    guard <= 1'b0;
    meas(1'b1, 1'b0, n);
    rng(n, (WP[2] - 1) * TC - 6, WP[2] * TC + 4);
    rdc(svw_pkg::ADDR_STATE, 32'h0000000A);
    wr(svw_pkg::ADDR_IRQ_MSK, 32'h00000001);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h00000001);
    wr(svw_pkg::ADDR_IRQ_STS, 32'h00000007);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h00000000);
    // Watchdog turned off while running; the write-done event drives the interrupt
    wr(svw_pkg::ADDR_IRQ_MSK, 32'h00000003);
    nvw();
    wr(svw_pkg::ADDR_CTRL, 32'h0000000C);
    guard <= 1'b1;
    repeat (100) @(posedge hclk);
    guard <= 1'b0;
    chk({31'h0, irq}, 32'h00000001);
    rdc(svw_pkg::ADDR_STATE, 32'h00000000);
    // Second reset in mid-run
    hresetn <= 1'b0;
    @(posedge hclk);
    chk({28'h0, reset_out_n, watchdog_out_n, irq, hresp}, 32'h00000004);
    chk(hrdata, 32'h00000000);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    meas(1'b0, 1'b1, n);
    rng(n, (PT1 - 1) * TC, PT1 * TC + 6);
    rdc(svw_pkg::ADDR_CTRL, 32'h0000000D);
    conclude();
  end
endmodule : svw_core_tb
